// file: verilog/iot_pkg.sv
// Package with register map, field positions, reset values and constants for the trip block.
package iot_pkg;
    // Register byte offsets.
    localparam logic [11:0] IOT_OFF_CTRL = 12'h000;
    localparam logic [11:0] IOT_OFF_LIM_PRI = 12'h004;
    localparam logic [11:0] IOT_OFF_LIM_SEC = 12'h008;
    localparam logic [11:0] IOT_OFF_TMS = 12'h00C;
    localparam logic [11:0] IOT_OFF_DT_LEVEL = 12'h010;
    localparam logic [11:0] IOT_OFF_MIN_TIME = 12'h014;
    localparam logic [11:0] IOT_OFF_DECAY = 12'h018;
    localparam logic [11:0] IOT_OFF_STATUS = 12'h01C;
    localparam logic [11:0] IOT_OFF_MAXCUR = 12'h020;
    localparam logic [11:0] IOT_OFF_HEAT = 12'h024;
    localparam logic [11:0] IOT_OFF_INT_STAT = 12'h028;
    localparam logic [11:0] IOT_OFF_INT_MASK = 12'h02C;

    // Control field positions.
    localparam int IOT_CTRL_ENABLE = 0;
    localparam int IOT_CTRL_SEC_SEL = 1;
    localparam int IOT_CTRL_SHUTDOWN = 2;
    localparam int IOT_CTRL_CLEAR = 3;

    // Status field positions.
    localparam int IOT_ST_OVER = 0;
    localparam int IOT_ST_SEVERE = 1;
    localparam int IOT_ST_TRIPPED = 2;
    localparam int IOT_ST_SEC = 3;

    // Interrupt field positions.
    localparam int IOT_INT_TRIP = 0;
    localparam int IOT_INT_START = 1;
    localparam int IOT_INT_END = 2;
    localparam int IOT_INT_W = 3;

    // Widths.
    localparam int IOT_CUR_W = 16;
    localparam int IOT_HEAT_W = 48;

    // Reset values.
    localparam logic [2:0] IOT_RST_CTRL = 3'h0;
    localparam logic [15:0] IOT_RST_LIMIT = 16'hFFFF;
    localparam logic [15:0] IOT_RST_TMS = 16'h0024;
    localparam logic [15:0] IOT_RST_DT_LEVEL = 16'hFFFF;
    localparam logic [15:0] IOT_RST_MIN_TIME = 16'h0002;
    localparam logic [31:0] IOT_RST_DECAY = 32'h0000_1000;
    localparam logic [2:0] IOT_RST_INT_MASK = 3'h0;
endpackage : iot_pkg

// file: verilog/iot_phase_max.sv
// Picks the largest of the three phase current magnitudes.
`timescale 1ns/100ps
module iot_phase_max
    import iot_pkg::*;
(
    input wire logic [iot_pkg::IOT_CUR_W-1:0] cur_a,
    input wire logic [iot_pkg::IOT_CUR_W-1:0] cur_b,
    input wire logic [iot_pkg::IOT_CUR_W-1:0] cur_c,
    output logic [iot_pkg::IOT_CUR_W-1:0] cur_max
);
    logic [IOT_CUR_W-1:0] ab;

    // Two compare stages; ties resolve to the earlier phase, which is harmless.
    always_comb begin
        ab = (cur_a >= cur_b) ? cur_a : cur_b;
        cur_max = (ab >= cur_c) ? ab : cur_c;
    end
endmodule : iot_phase_max

// file: verilog/iot_trip.sv
// Inverse-time overcurrent trip detector with APB registers and interrupt.
//
// What this block does
// - Over the limit, trip after multiplier divided by squared relative excess seconds.
// - Multiplier equals trip time in seconds at double the limit current.
// - The largest phase current drives every evaluation.
// - Current at or below the limit never trips, however long.
// - Above a high current level the delay stays at a fixed minimum.
// - Heat left from an untripped overload shortens the next trip.
// - Separate primary and secondary limits; secondary set selects secondary limit.
// - Configuration picks load-dump alarm or immediate shutdown alarm on trip.
// - With multiplier 36 the delays follow the percent-load reference table.
`timescale 1ns/100ps
module iot_trip
    import iot_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [iot_pkg::IOT_CUR_W-1:0] cur_a,
    input wire logic [iot_pkg::IOT_CUR_W-1:0] cur_b,
    input wire logic [iot_pkg::IOT_CUR_W-1:0] cur_c,
    input wire logic sec_tick,
    output logic loaddump_alarm,
    output logic shutdown_alarm,
    output logic irq
);
    import iot_pkg::*;

    logic [2:0] ctrl_q;
    logic [15:0] lim_pri_q;
    logic [15:0] lim_sec_q;
    logic [15:0] tms_q;
    logic [15:0] dt_level_q;
    logic [15:0] min_time_q;
    logic [31:0] decay_q;
    logic [IOT_INT_W-1:0] int_stat_q;
    logic [IOT_INT_W-1:0] int_mask_q;
    logic [31:0] prdata_q;
    logic irq_q;

    logic [IOT_CUR_W-1:0] max_now;
    logic [IOT_CUR_W-1:0] max_q;
    logic [IOT_HEAT_W-1:0] heat_q;
    logic [15:0] dt_cnt_q;
    logic tripped_q;
    logic over_prev_q;
    logic ld_alarm_q;
    logic sd_alarm_q;

    logic wr_en;
    logic setup;
    logic mapped;
    logic clear_req;
    logic [15:0] lim;
    logic over;
    logic severe;
    logic [15:0] icalc;
    logic [15:0] excess;
    logic [31:0] excess_sq;
    logic [IOT_HEAT_W-1:0] thr;
    logic [IOT_HEAT_W:0] heat_sum;
    logic [IOT_HEAT_W-1:0] heat_add;
    logic [IOT_HEAT_W-1:0] heat_dec;
    logic active_tick;
    logic inv_trip;
    logic dt_trip;
    logic trip_now;
    logic [IOT_INT_W-1:0] ev;

    // Largest phase, registered so a tick sees a settled value.
    iot_phase_max u_max (
        .cur_a(cur_a),
        .cur_b(cur_b),
        .cur_c(cur_c),
        .cur_max(max_now)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_q <= '0;
        end else begin
            max_q <= max_now;
        end
    end

    // Bus decode; the slave never inserts wait states.
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && mapped;
    assign clear_req = wr_en && (paddr == IOT_OFF_CTRL) && pwdata[IOT_CTRL_CLEAR];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    always_comb begin
        case (paddr)
            IOT_OFF_CTRL, IOT_OFF_LIM_PRI, IOT_OFF_LIM_SEC, IOT_OFF_TMS,
            IOT_OFF_DT_LEVEL, IOT_OFF_MIN_TIME, IOT_OFF_DECAY, IOT_OFF_STATUS,
            IOT_OFF_MAXCUR, IOT_OFF_HEAT, IOT_OFF_INT_STAT, IOT_OFF_INT_MASK: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Configuration registers; read-only offsets ignore writes without error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= IOT_RST_CTRL;
            lim_pri_q <= IOT_RST_LIMIT;
            lim_sec_q <= IOT_RST_LIMIT;
            tms_q <= IOT_RST_TMS;
            dt_level_q <= IOT_RST_DT_LEVEL;
            min_time_q <= IOT_RST_MIN_TIME;
            decay_q <= IOT_RST_DECAY;
            int_mask_q <= IOT_RST_INT_MASK;
        end else if (wr_en) begin
            case (paddr)
                IOT_OFF_CTRL: ctrl_q <= pwdata[2:0];
                IOT_OFF_LIM_PRI: lim_pri_q <= pwdata[15:0];
                IOT_OFF_LIM_SEC: lim_sec_q <= pwdata[15:0];
                IOT_OFF_TMS: tms_q <= pwdata[15:0];
                IOT_OFF_DT_LEVEL: dt_level_q <= pwdata[15:0];
                IOT_OFF_MIN_TIME: min_time_q <= pwdata[15:0];
                IOT_OFF_DECAY: decay_q <= pwdata;
                IOT_OFF_INT_MASK: int_mask_q <= pwdata[IOT_INT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                IOT_OFF_CTRL: prdata_q <= {29'h0, ctrl_q};
                IOT_OFF_LIM_PRI: prdata_q <= {16'h0, lim_pri_q};
                IOT_OFF_LIM_SEC: prdata_q <= {16'h0, lim_sec_q};
                IOT_OFF_TMS: prdata_q <= {16'h0, tms_q};
                IOT_OFF_DT_LEVEL: prdata_q <= {16'h0, dt_level_q};
                IOT_OFF_MIN_TIME: prdata_q <= {16'h0, min_time_q};
                IOT_OFF_DECAY: prdata_q <= decay_q;
                IOT_OFF_STATUS: prdata_q <= {28'h0, ctrl_q[IOT_CTRL_SEC_SEL], tripped_q,
                                             severe, over};
                IOT_OFF_MAXCUR: prdata_q <= {16'h0, max_q};
                IOT_OFF_HEAT: prdata_q <= heat_q[IOT_HEAT_W-1:16];
                IOT_OFF_INT_STAT: prdata_q <= {29'h0, int_stat_q};
                IOT_OFF_INT_MASK: prdata_q <= {29'h0, int_mask_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Active limit follows the selected setting set.
    assign lim = ctrl_q[IOT_CTRL_SEC_SEL] ? lim_sec_q : lim_pri_q;

    // Strictly above the limit counts as overload; equality is allowed forever.
    assign over = (max_q > lim);
    assign severe = over && (max_q >= dt_level_q);

    // Clamping the current at the definite-time level freezes the inverse delay there.
    assign icalc = (max_q > dt_level_q) ? dt_level_q : max_q;
    assign excess = (icalc > lim) ? (icalc - lim) : 16'h0000;

    // Heat grows by excess squared per second and trips at multiplier times limit
    // squared, so the delay is TMS*L^2/(I-L)^2 = TMS/(I/L-1)^2 with no divider.
    always_comb begin
        excess_sq = 32'(excess) * 32'(excess);
        thr = 48'(tms_q) * 48'(lim) * 48'(lim);
        heat_sum = {1'b0, heat_q} + {17'h0, excess_sq};
        heat_add = heat_sum[IOT_HEAT_W] ? {IOT_HEAT_W{1'b1}} : heat_sum[IOT_HEAT_W-1:0];
        heat_dec = (heat_q > {16'h0, decay_q}) ? (heat_q - {16'h0, decay_q}) : '0;
    end

    assign active_tick = sec_tick && ctrl_q[IOT_CTRL_ENABLE] && !tripped_q;
    assign inv_trip = over && (heat_add >= thr);
    assign dt_trip = severe && ((17'(dt_cnt_q) + 17'h1) >= 17'(min_time_q));
    assign trip_now = active_tick && (inv_trip || dt_trip);

    // Heat accumulator: it keeps its residue after an untripped overload and
    // cools at the programmed rate until a clear or disable zeroes it, so a repeat overload trips sooner.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heat_q <= '0;
        end else if (clear_req || !ctrl_q[IOT_CTRL_ENABLE]) begin
            heat_q <= '0;
        end else if (active_tick) begin
            if (over) begin
                heat_q <= heat_add;
            end else begin
                heat_q <= heat_dec;
            end
        end
    end

    // Definite-time counter runs only while the current stays severe.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dt_cnt_q <= 16'h0000;
        end else if (clear_req || !severe || !ctrl_q[IOT_CTRL_ENABLE]) begin
            dt_cnt_q <= 16'h0000;
        end else if (active_tick && dt_cnt_q != 16'hFFFF) begin
            dt_cnt_q <= dt_cnt_q + 16'h0001;
        end
    end

    // Trip latch and alarm kind; the kind is fixed at the moment of the trip.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tripped_q <= 1'b0;
            ld_alarm_q <= 1'b0;
            sd_alarm_q <= 1'b0;
        end else if (trip_now) begin
            tripped_q <= 1'b1;
            ld_alarm_q <= !ctrl_q[IOT_CTRL_SHUTDOWN];
            sd_alarm_q <= ctrl_q[IOT_CTRL_SHUTDOWN];
        end else if (clear_req) begin
            tripped_q <= 1'b0;
            ld_alarm_q <= 1'b0;
            sd_alarm_q <= 1'b0;
        end
    end

    assign loaddump_alarm = ld_alarm_q;
    assign shutdown_alarm = sd_alarm_q;

    // Overload state as seen at the previous tick, for start and end events.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_prev_q <= 1'b0;
        end else if (clear_req) begin
            over_prev_q <= 1'b0;
        end else if (active_tick) begin
            over_prev_q <= over;
        end
    end

    always_comb begin
        ev = '0;
        ev[IOT_INT_TRIP] = trip_now;
        ev[IOT_INT_START] = active_tick && over && !over_prev_q;
        ev[IOT_INT_END] = active_tick && !over && over_prev_q;
    end

    // Sticky status, write one to clear; a new event in the same cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= '0;
        end else if (wr_en && paddr == IOT_OFF_INT_STAT) begin
            int_stat_q <= (int_stat_q & ~pwdata[IOT_INT_W-1:0]) | ev;
        end else begin
            int_stat_q <= int_stat_q | ev;
        end
    end

    // Registered interrupt level, one cycle behind the status bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    assign irq = irq_q;
endmodule : iot_trip

// file: dv/iot_trip_checker.sv
// Concurrent checks on the trip block's bus, alarm and interrupt ports.
`timescale 1ns/100ps
module iot_trip_checker
    import iot_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sec_tick,
    input wire logic loaddump_alarm,
    input wire logic shutdown_alarm,
    input wire logic irq
);
    import iot_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A clear is a completed control write with the clear bit set.
    wire logic clr = psel && penable && pwrite && paddr == IOT_OFF_CTRL && pwdata[IOT_CTRL_CLEAR];
    wire logic acc_wr = psel && penable && pwrite;
    wire logic alarm = loaddump_alarm || shutdown_alarm;
    // A tick in the same cycle may trip again, so only a lone clear must drop the alarms.
    sequence s_clear;
        clr && !sec_tick;
    endsequence
    sequence s_unmapped;
        psel && penable && paddr > IOT_OFF_INT_MASK;
    endsequence
    sequence s_irq_rise;
        !irq ##1 irq;
    endsequence
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_unmapped_err: assert property (s_unmapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_alarm_onehot: assert property (!(loaddump_alarm && shutdown_alarm))
        else $error("both alarms high");
    chk_trip_on_tick: assert property ($rose(alarm) |-> $past(sec_tick))
        else $error("alarm rose without a tick");
    chk_alarm_kept: assert property ($fell(alarm) |-> $past(clr))
        else $error("alarm dropped without clear");
    chk_clear_drops: assert property (s_clear |=> !alarm)
        else $error("alarm survived clear");
    chk_irq_cause: assert property (s_irq_rise |-> $past(sec_tick || acc_wr, 2))
        else $error("irq rose without cause");
    chk_irq_fall: assert property ($fell(irq) |-> $past(acc_wr, 2))
        else $error("irq fell without write");
endmodule : iot_trip_checker

bind iot_trip iot_trip_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sec_tick(sec_tick), .loaddump_alarm(loaddump_alarm),
    .shutdown_alarm(shutdown_alarm), .irq(irq));

// file: dv/iot_plant_model.sv
// Stand-in for the phase current transducers and the engine stop sequencer.
`timescale 1ns/100ps
module iot_plant_model
    import iot_pkg::*;
#(
    parameter int COOL_CYCLES = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [iot_pkg::IOT_CUR_W-1:0] amps,
    input wire logic tick_req,
    input wire logic loaddump_alarm,
    input wire logic shutdown_alarm,
    output logic [iot_pkg::IOT_CUR_W-1:0] cur_a,
    output logic [iot_pkg::IOT_CUR_W-1:0] cur_b,
    output logic [iot_pkg::IOT_CUR_W-1:0] cur_c,
    output logic sec_tick,
    output logic running
);
    import iot_pkg::*;
    logic [7:0] cool_q;
    logic [1:0] rot_q;
    // The loaded phase moves on at every tick, so a picker that favours one input
    // would see a lighter phase on some ticks and trip late.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_a <= '0;
            cur_b <= '0;
            cur_c <= '0;
            sec_tick <= 1'b0;
            rot_q <= 2'h0;
        end else begin
            cur_a <= (rot_q == 2'h0) ? amps : amps >> 1;
            cur_b <= (rot_q == 2'h1) ? amps : amps >> 2;
            cur_c <= (rot_q == 2'h2) ? amps : amps >> 1;
            sec_tick <= tick_req;
            if (tick_req) begin
                rot_q <= (rot_q == 2'h2) ? 2'h0 : rot_q + 2'h1;
            end
        end
    end
    // Shutdown stops at once, load dump only after the cooldown run.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || !(loaddump_alarm || shutdown_alarm)) begin
            running <= 1'b1;
            cool_q <= 8'h00;
        end else if (shutdown_alarm || cool_q == 8'(COOL_CYCLES - 1)) begin
            running <= 1'b0;
        end else begin
            cool_q <= cool_q + 8'h01;
        end
    end
endmodule : iot_plant_model

// file: dv/testbench.sv
// Self-checking bench for the inverse-time trip block.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import iot_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tick_req = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, ctrl;
    logic pready, pslverr, err, ld, sd, irq, running, sec_tick;
    logic [15:0] amps = '0, cur_a, cur_b, cur_c;
    logic [11:0] oa [7] = '{IOT_OFF_CTRL, IOT_OFF_LIM_PRI, IOT_OFF_TMS, IOT_OFF_DT_LEVEL,
        IOT_OFF_MIN_TIME, IOT_OFF_DECAY, IOT_OFF_INT_MASK};
    logic [31:0] ea [7] = '{32'h0, 32'hFFFF, 32'h24, 32'hFFFF, 32'h2, 32'h1000, 32'h0};
    int errors = 0, n_tests = 0;
    iot_trip dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c), .sec_tick(sec_tick),
        .loaddump_alarm(ld), .shutdown_alarm(sd), .irq(irq));
    iot_plant_model plant (.pclk(pclk), .presetn(presetn), .amps(amps), .tick_req(tick_req),
        .loaddump_alarm(ld), .shutdown_alarm(sd), .cur_a(cur_a), .cur_b(cur_b),
        .cur_c(cur_c), .sec_tick(sec_tick), .running(running));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Currents need two clocks to reach the detector, so settle before any tick.
    task automatic load(input logic [15:0] i);
        amps <= i;
        repeat (4) @(posedge pclk);
    endtask : load
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            tick_req <= 1'b1;
            @(posedge pclk);
            tick_req <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask : ticks
    // Clears heat and alarms, then expects the trip on exactly tick n.
    task automatic run(input logic [15:0] i, input int n);
        apb(1, IOT_OFF_CTRL, ctrl | 32'h8);
        load(i);
        ticks(n - 1);
        `CHK(ld | sd, 1'b0)
        ticks(1);
        `CHK(ld | sd, 1'b1)
    endtask : run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        #1500000;
        errors++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int j = 0; j < 7; j++) begin
            apb(0, oa[j], 32'h0);
            `CHK(rd, ea[j])
        end
        apb(0, 12'h040, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        $display("test reset done");
        apb(1, IOT_OFF_LIM_PRI, 32'h64);
        apb(1, IOT_OFF_TMS, 32'h4);
        ctrl = 32'h1;
        run(16'hC8, 4);
        `CHK({ld, sd, running}, 3'b101)
        repeat (10) @(posedge pclk);
        `CHK(running, 1'b0)
        apb(0, IOT_OFF_INT_STAT, 32'h0);
        `CHK({rd, irq}, 33'h6)
        apb(1, IOT_OFF_INT_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1, IOT_OFF_INT_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        apb(0, IOT_OFF_INT_STAT, 32'h0);
        `CHK({rd, irq}, 33'h4)
        $display("test trip and interrupt done");
        apb(1, IOT_OFF_CTRL, 32'h9);
        load(16'h64);
        ticks(20);
        apb(0, IOT_OFF_STATUS, 32'h0);
        `CHK({rd, ld, sd}, 34'h0)
        $display("test at limit done");
        apb(1, IOT_OFF_TMS, 32'h24);
        run(16'h6E, 3600);
        run(16'h96, 144);
        run(16'hC8, 36);
        run(16'h12C, 9);
        $display("test delay table done");
        apb(1, IOT_OFF_TMS, 32'h4);
        apb(1, IOT_OFF_CTRL, 32'h9);
        load(16'hC8);
        ticks(2);
        load(16'h64);
        ticks(1);
        load(16'hC8);
        ticks(2);
        `CHK(ld, 1'b0)
        ticks(1);
        `CHK(ld, 1'b1)
        apb(0, IOT_OFF_INT_STAT, 32'h0);
        `CHK({rd, irq}, 33'hF)
        $display("test residual heat done");
        apb(1, IOT_OFF_TMS, 32'h24);
        apb(1, IOT_OFF_DT_LEVEL, 32'h96);
        ctrl = 32'h5;
        run(16'h3E8, 2);
        `CHK({ld, sd}, 2'b01)
        $display("test definite time done");
        apb(1, IOT_OFF_DT_LEVEL, 32'hFFFF);
        apb(1, IOT_OFF_LIM_SEC, 32'h12C);
        apb(1, IOT_OFF_TMS, 32'h1);
        apb(1, IOT_OFF_CTRL, 32'hB);
        load(16'hC8);
        ticks(5);
        apb(0, IOT_OFF_STATUS, 32'h0);
        `CHK({rd, ld, sd}, 34'h20)
        apb(0, IOT_OFF_MAXCUR, 32'h0);
        `CHK(rd, 32'hC8)
        $display("test secondary limit done");
        conclude();
    end
endmodule : testbench
